// [hdl/msm_pkg.sv]
// constants, types and settings layout for the setup menu block
// assumes one 40 MHz clock and buttons already debounced upstream
package msm_pkg;

    localparam int unsigned CLK_HZ          = 40000000;
    localparam int unsigned ENTER_HOLD_MS   = 1000;
    localparam int unsigned EXIT_HOLD_MS    = 2000;
    localparam int unsigned ENTER_CYCLES    = CLK_HZ / 1000 * ENTER_HOLD_MS;
    localparam int unsigned EXIT_CYCLES     = CLK_HZ / 1000 * EXIT_HOLD_MS;
    localparam int unsigned CAL_SHOW_CYCLES = 4;

    // swr in tenths
    localparam logic [5:0] SWR_MIN   = 6'h0A;
    localparam logic [5:0] SWR_MAX   = 6'h32;
    localparam logic [5:0] SWR_RESET = 6'h23;

    localparam logic [2:0] THRESH_LAST  = 3'h4;
    localparam logic [2:0] THRESH_RESET = 3'h0;

    // option list last indices and reset indices (15 W, 100 W, 1500 W)
    localparam logic [3:0] LOW_LAST  = 4'h4;
    localparam logic [3:0] MID_LAST  = 4'h8;
    localparam logic [3:0] HIGH_LAST = 4'h9;
    localparam logic [3:0] LOW_RESET  = 4'h2;
    localparam logic [3:0] MID_RESET  = 4'h2;
    localparam logic [3:0] HIGH_RESET = 4'h4;

    localparam logic [4:0] WIDTH_MIN   = 5'h01;
    localparam logic [4:0] WIDTH_MAX   = 5'h14;
    localparam logic [4:0] WIDTH_RESET = 5'h0C;
    localparam logic [4:0] WIDTH_PEAK  = 5'h0D;

    localparam logic [4:0] AVG_MIN   = 5'h02;
    localparam logic [4:0] AVG_MAX   = 5'h18;
    localparam logic [4:0] AVG_RESET = 5'h08;

    // hold in quarter seconds
    localparam logic [4:0] HOLD_MIN   = 5'h01;
    localparam logic [4:0] HOLD_MAX   = 5'h14;
    localparam logic [4:0] HOLD_RESET = 5'h08;

    localparam logic [1:0] DECAY_MAX   = 2'h2;
    localparam logic [1:0] DECAY_RESET = 2'h1;
    localparam logic [7:0] SLOW_DECAY_TENTHS = 8'h1E;

    localparam logic [2:0] COUPLER_LAST  = 3'h5;
    localparam logic [2:0] COUPLER_RESET = 3'h0;
    localparam logic [2:0] COUPLER_5KW_A = 3'h1;
    localparam logic [2:0] COUPLER_5KW_B = 3'h3;
    localparam logic [2:0] COUPLER_10KW  = 3'h4;

    localparam logic [2:0] REST_LAST  = 3'h4;
    localparam logic [2:0] REST_HOLD  = 3'h4;
    localparam logic [2:0] REST_RESET = 3'h0;

    // scale factors in hundredths
    localparam logic [8:0] SCALE_1X  = 9'h064;
    localparam logic [8:0] SCALE_5KW = 9'h0A7;
    localparam logic [8:0] SCALE_10K = 9'h14D;

    typedef enum logic [12:0] {
        SCR_OPERATE = 13'h0001,
        SCR_REF     = 13'h0002,
        SCR_ALARM   = 13'h0004,
        SCR_THRESH  = 13'h0008,
        SCR_RANGE   = 13'h0010,
        SCR_WIDTH   = 13'h0020,
        SCR_AVG     = 13'h0040,
        SCR_HOLD    = 13'h0080,
        SCR_DECAY   = 13'h0100,
        SCR_COUPLER = 13'h0200,
        SCR_REST    = 13'h0400,
        SCR_LOWER   = 13'h0800,
        SCR_CAL     = 13'h1000
    } msm_screen_type;

    typedef struct packed {
        logic mode;
        logic step_down_button;
        logic up;
    } msm_buttons_type;

    typedef struct packed {
        logic [5:0] swr_setpoint;
        logic [2:0] alarm_power_threshold;
        logic       power_net;
        logic       temp_celsius;
        logic [4:0] avg_samples;
        logic [4:0] hold_quarters;
        logic [1:0] decay;
        logic [2:0] coupler;
        logic [2:0] rest_style;
        logic       lower_reflected;
    } msm_settings_type;

    typedef struct packed {
        logic [15:0] max_watts;
        logic [15:0] span_watts;
        logic [4:0]  width_db;
        logic [1:0]  scale_sel;
    } msm_bargraph_type;

endpackage : msm_pkg

// [hdl/msm_menu.sv]
// setup menu state and stored display/alarm settings
// assumes buttons are raw pins; synchronised and edge-detected here
`timescale 1ns/10ps

module msm_menu
    import msm_pkg::*;
#(
    parameter int unsigned ENTER_HOLD = ENTER_CYCLES,
    parameter int unsigned EXIT_HOLD  = EXIT_CYCLES
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    // front panel
    input  wire msm_buttons_type  buttons_in,
    input  wire logic             peak_mode_in,
    input  wire logic             transmitting_in,
    input  wire logic [7:0]       swr_live_in,
    // menu status
    output msm_screen_type        screen_out,
    output logic                  cpu_reset_out,
    output msm_settings_type      settings_out,
    output msm_bargraph_type      bargraph_out,
    output logic                  attack_fast_out,
    output logic [7:0]            swr_rest_out,
    output logic                  swr_rest_valid_out
);

    ////////////////////////////////////////////////////////////////////
    // synchronise and detect presses
    msm_buttons_type sync1_reg;
    msm_buttons_type sync2_reg;
    msm_buttons_type prev_reg;
    logic            tx_sync1_reg;
    logic            tx_sync2_reg;
    logic            tx_prev_reg;
    logic            dn_press;
    logic            up_press;
    logic            mode_release;
    logic            tx_start;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sync1_reg    <= '0;
            sync2_reg    <= '0;
            prev_reg     <= '0;
            tx_sync1_reg <= 1'b0;
            tx_sync2_reg <= 1'b0;
            tx_prev_reg  <= 1'b0;
        end else begin
            sync1_reg    <= buttons_in;
            sync2_reg    <= sync1_reg;
            prev_reg     <= sync2_reg;
            tx_sync1_reg <= transmitting_in;
            tx_sync2_reg <= tx_sync1_reg;
            tx_prev_reg  <= tx_sync2_reg;
        end
    end

    assign dn_press     = sync2_reg.step_down_button & ~prev_reg.step_down_button;
    assign up_press     = sync2_reg.up & ~prev_reg.up;
    assign mode_release = ~sync2_reg.mode & prev_reg.mode;
    assign tx_start     = tx_sync2_reg & ~tx_prev_reg;

    ////////////////////////////////////////////////////////////////////
    // mode hold timer; counts one press, fires once per hold
    logic [26:0] hold_reg;
    logic        hold_fired_reg;
    logic        enter_hit;
    logic        exit_hit;

    assign enter_hit = sync2_reg.mode && !hold_fired_reg && hold_reg == 27'(ENTER_HOLD - 1);
    assign exit_hit  = sync2_reg.mode && !hold_fired_reg && hold_reg == 27'(EXIT_HOLD - 1);

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            hold_reg       <= '0;
            hold_fired_reg <= 1'b0;
        end else if (!sync2_reg.mode) begin
            hold_reg       <= '0;
            hold_fired_reg <= 1'b0;
        end else begin
            hold_reg <= hold_reg + 27'h0000001;
            if ((screen_out == SCR_OPERATE && enter_hit) || (screen_out != SCR_OPERATE && exit_hit))
                hold_fired_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // screen sequencing
    logic [2:0] cal_cnt_reg;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            screen_out  <= SCR_OPERATE;
            cal_cnt_reg <= '0;
        end else begin
            case (screen_out)
                SCR_OPERATE: if (enter_hit) screen_out <= SCR_REF;
                SCR_CAL: begin
                    // brief pass through calibration on the way out
                    cal_cnt_reg <= cal_cnt_reg + 3'h1;
                    if (cal_cnt_reg == 3'(CAL_SHOW_CYCLES - 1)) begin
                        screen_out  <= SCR_OPERATE;
                        cal_cnt_reg <= '0;
                    end
                end
                default: begin
                    if (exit_hit) begin
                        screen_out <= SCR_CAL;
                    end else if (mode_release && !hold_fired_reg) begin
                        // a short tap steps to the next screen
                        case (screen_out)
                            SCR_REF:     screen_out <= SCR_ALARM;
                            SCR_ALARM:   screen_out <= SCR_THRESH;
                            SCR_THRESH:  screen_out <= SCR_RANGE;
                            SCR_RANGE:   screen_out <= SCR_WIDTH;
                            SCR_WIDTH:   screen_out <= SCR_AVG;
                            SCR_AVG:     screen_out <= SCR_HOLD;
                            SCR_HOLD:    screen_out <= SCR_DECAY;
                            SCR_DECAY:   screen_out <= SCR_COUPLER;
                            SCR_COUPLER: screen_out <= SCR_REST;
                            SCR_REST:    screen_out <= SCR_LOWER;
                            default:     screen_out <= SCR_REF;
                        endcase
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // processor reset pulse
    always_ff @(posedge clk_in) begin
        if (reset_in)
            cpu_reset_out <= 1'b0;
        else
            cpu_reset_out <= (screen_out == SCR_REF) && dn_press;
    end

    ////////////////////////////////////////////////////////////////////
    // settings edits
    logic [3:0] low_idx_reg;
    logic [3:0] mid_idx_reg;
    logic [3:0] high_idx_reg;
    logic [1:0] scale_sel_reg;
    logic [4:0] width_reg;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            settings_out.swr_setpoint          <= SWR_RESET;
            settings_out.alarm_power_threshold <= THRESH_RESET;
            settings_out.power_net             <= 1'b1;
            settings_out.temp_celsius          <= 1'b0;
            settings_out.avg_samples           <= AVG_RESET;
            settings_out.hold_quarters         <= HOLD_RESET;
            settings_out.decay                 <= DECAY_RESET;
            settings_out.coupler               <= COUPLER_RESET;
            settings_out.rest_style            <= REST_RESET;
            settings_out.lower_reflected       <= 1'b0;
            low_idx_reg   <= LOW_RESET;
            mid_idx_reg   <= MID_RESET;
            high_idx_reg  <= HIGH_RESET;
            scale_sel_reg <= 2'h0;
            width_reg     <= WIDTH_RESET;
        end else begin
            case (screen_out)
                SCR_REF:
                    if (up_press) settings_out.temp_celsius <= ~settings_out.temp_celsius;
                SCR_ALARM: begin
                    if (dn_press && settings_out.swr_setpoint > SWR_MIN)
                        settings_out.swr_setpoint <= settings_out.swr_setpoint - 6'h01;
                    else if (up_press && settings_out.swr_setpoint < SWR_MAX)
                        settings_out.swr_setpoint <= settings_out.swr_setpoint + 6'h01;
                end
                SCR_THRESH: begin
                    if (dn_press)
                        settings_out.alarm_power_threshold <= (settings_out.alarm_power_threshold == THRESH_LAST)
                            ? 3'h0 : settings_out.alarm_power_threshold + 3'h1;
                    if (up_press) settings_out.power_net <= ~settings_out.power_net;
                end
                SCR_RANGE: begin
                    if (dn_press)
                        scale_sel_reg <= (scale_sel_reg == 2'h2) ? 2'h0 : scale_sel_reg + 2'h1;
                    if (up_press) begin
                        case (scale_sel_reg)
                            2'h0: low_idx_reg  <= (low_idx_reg == LOW_LAST) ? 4'h0 : low_idx_reg + 4'h1;
                            2'h1: mid_idx_reg  <= (mid_idx_reg == MID_LAST) ? 4'h0 : mid_idx_reg + 4'h1;
                            default: high_idx_reg <= (high_idx_reg == HIGH_LAST) ? 4'h0 : high_idx_reg + 4'h1;
                        endcase
                    end
                end
                SCR_WIDTH: begin
                    if (dn_press && width_reg > WIDTH_MIN)
                        width_reg <= width_reg - 5'h01;
                    else if (up_press && width_reg < WIDTH_MAX)
                        width_reg <= width_reg + 5'h01;
                end
                SCR_AVG: begin
                    if (dn_press && settings_out.avg_samples > AVG_MIN)
                        settings_out.avg_samples <= settings_out.avg_samples - 5'h01;
                    else if (up_press && settings_out.avg_samples < AVG_MAX)
                        settings_out.avg_samples <= settings_out.avg_samples + 5'h01;
                end
                SCR_HOLD: begin
                    if (dn_press && settings_out.hold_quarters > HOLD_MIN)
                        settings_out.hold_quarters <= settings_out.hold_quarters - 5'h01;
                    else if (up_press && settings_out.hold_quarters < HOLD_MAX)
                        settings_out.hold_quarters <= settings_out.hold_quarters + 5'h01;
                end
                SCR_DECAY: begin
                    if (dn_press && settings_out.decay != 2'h0)
                        settings_out.decay <= settings_out.decay - 2'h1;
                    else if (up_press && settings_out.decay != DECAY_MAX)
                        settings_out.decay <= settings_out.decay + 2'h1;
                end
                SCR_COUPLER: begin
                    if (dn_press)
                        settings_out.coupler <= (settings_out.coupler == 3'h0) ? COUPLER_LAST
                            : settings_out.coupler - 3'h1;
                    else if (up_press)
                        settings_out.coupler <= (settings_out.coupler == COUPLER_LAST) ? 3'h0
                            : settings_out.coupler + 3'h1;
                end
                SCR_REST: begin
                    if (dn_press)
                        settings_out.rest_style <= (settings_out.rest_style == 3'h0) ? REST_LAST
                            : settings_out.rest_style - 3'h1;
                    else if (up_press)
                        settings_out.rest_style <= (settings_out.rest_style == REST_LAST) ? 3'h0
                            : settings_out.rest_style + 3'h1;
                end
                SCR_LOWER:
                    if (dn_press || up_press)
                        settings_out.lower_reflected <= ~settings_out.lower_reflected;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bargraph scale derivation
    function automatic logic [15:0] max_watts(input logic [1:0] sel, input logic [3:0] idx);
        logic [15:0] w;
        w = 16'h0000;
        case (sel)
            2'h0: w = 16'(5 * (int'(idx) + 1));
            2'h1: w = 16'(50 + 25 * int'(idx));
            default: w = (idx == HIGH_LAST) ? 16'h0BB8 : 16'(500 + 250 * int'(idx));
        endcase
        return w;
    endfunction : max_watts

    logic [3:0]  sel_idx;
    logic [8:0]  scale;
    logic [31:0] scaled;

    always_comb begin
        case (scale_sel_reg)
            2'h0:    sel_idx = low_idx_reg;
            2'h1:    sel_idx = mid_idx_reg;
            default: sel_idx = high_idx_reg;
        endcase
        case (settings_out.coupler)
            COUPLER_5KW_A, COUPLER_5KW_B: scale = SCALE_5KW;
            COUPLER_10KW:                 scale = SCALE_10K;
            default:                      scale = SCALE_1X;
        endcase
        scaled = 32'(max_watts(scale_sel_reg, sel_idx)) * 32'(scale) / 32'd100;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            bargraph_out    <= '0;
            attack_fast_out <= 1'b1;
        end else begin
            bargraph_out.max_watts  <= scaled[15:0];
            bargraph_out.span_watts <= scaled[15:0] + 16'(scaled / 32'd10);
            bargraph_out.width_db   <= peak_mode_in ? WIDTH_PEAK : width_reg;
            bargraph_out.scale_sel  <= scale_sel_reg;
            attack_fast_out         <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // resting swr; hold-last latch cleared when a new transmission starts
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            swr_rest_out       <= '0;
            swr_rest_valid_out <= 1'b0;
        end else if (tx_sync2_reg) begin
            swr_rest_out       <= swr_live_in;
            swr_rest_valid_out <= 1'b0;
            if (tx_start) swr_rest_out <= '0;
        end else begin
            swr_rest_valid_out <= (settings_out.rest_style == REST_HOLD);
        end
    end

endmodule : msm_menu

// [dv/msm_menu_chk.sv]
// checker for the setup menu block, ports only
// assumes it is bound to msm_menu with its hold parameters
`timescale 1ns/10ps
module msm_menu_chk
    import msm_pkg::*;
#(
    parameter int unsigned ENTER_HOLD = 20,
    parameter int unsigned EXIT_HOLD  = 40
) (
    // clock, reset, panel
    input wire logic             clk_in,
    input wire logic             reset_in,
    input wire msm_buttons_type  buttons_in,
    input wire logic             peak_mode_in,
    input wire logic             transmitting_in,
    input wire logic [7:0]       swr_live_in,
    // status
    input wire msm_screen_type   screen_out,
    input wire logic             cpu_reset_out,
    input wire msm_settings_type settings_out,
    input wire msm_bargraph_type bargraph_out,
    input wire logic             attack_fast_out,
    input wire logic [7:0]       swr_rest_out,
    input wire logic             swr_rest_valid_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // raw pin count; the synced level lags it, so entry needs at least this
    int unsigned hold_cnt;
    always_ff @(posedge clk_in) begin
        hold_cnt <= buttons_in.mode ? hold_cnt + 1 : 0;
    end
    ////////////////////////////////////////
    a_cpu_pulse_one: assert property (cpu_reset_out |=> !cpu_reset_out)
        else $error("cpu reset longer than one cycle");
    a_cpu_on_ref: assert property (cpu_reset_out |-> screen_out == SCR_REF)
        else $error("cpu reset off the reference screen");
    a_enter_hold: assert property ($past(screen_out) == SCR_OPERATE && screen_out == SCR_REF
        |-> hold_cnt >= ENTER_HOLD) else $error("setup entered on a short hold");
    a_cal_exit: assert property ($rose(screen_out == SCR_CAL) |-> ##[3:5] screen_out == SCR_OPERATE)
        else $error("calibration pass did not reach operate");
    a_swr_on_alarm: assert property ($changed(settings_out.swr_setpoint) |-> screen_out == SCR_ALARM)
        else $error("setpoint changed off its screen");
    a_thresh_on_scr: assert property ($changed(settings_out.alarm_power_threshold)
        |-> screen_out == SCR_THRESH) else $error("threshold changed off its screen");
    a_peak_width: assert property (peak_mode_in [*3] |-> bargraph_out.width_db == WIDTH_PEAK)
        else $error("peak width not fixed");
    a_span_ratio: assert property ($stable(bargraph_out.max_watts) [*2]
        |-> bargraph_out.span_watts == bargraph_out.max_watts + bargraph_out.max_watts / 16'h000A)
        else $error("span not maximum plus a tenth");
    a_attack_fast: assert property (attack_fast_out) else $error("attack not fast");
    a_rest_tx_clear: assert property (transmitting_in [*5] |-> !swr_rest_valid_out)
        else $error("held swr kept while transmitting");
    a_avg_bounds: assert property (settings_out.avg_samples inside {[AVG_MIN:AVG_MAX]})
        else $error("sample count out of range");
endmodule : msm_menu_chk

bind msm_menu msm_menu_chk #(.ENTER_HOLD(ENTER_HOLD), .EXIT_HOLD(EXIT_HOLD)) u_chk (
    .clk_in(clk_in), .reset_in(reset_in), .buttons_in(buttons_in), .peak_mode_in(peak_mode_in),
    .transmitting_in(transmitting_in), .swr_live_in(swr_live_in), .screen_out(screen_out),
    .cpu_reset_out(cpu_reset_out), .settings_out(settings_out), .bargraph_out(bargraph_out),
    .attack_fast_out(attack_fast_out), .swr_rest_out(swr_rest_out), .swr_rest_valid_out(swr_rest_valid_out));

// [dv/msm_panel.sv]
// operator front panel model: presses the buttons
// assumes the caller enters press just after a rising edge
`timescale 1ns/10ps
module msm_panel
    import msm_pkg::*;
(
    // clock
    input  wire logic      clk_in,
    // buttons, released pins read low
    output msm_buttons_type buttons_out
);
    initial buttons_out = '0;
    ////////////////////////////////////////
    // gap after release covers the sync stages and the edge detect
    task automatic press(input logic [2:0] mask, input int hold);
        @(posedge clk_in);
        buttons_out <= mask;
        repeat (hold) @(posedge clk_in);
        buttons_out <= 3'h0;
        repeat (10) @(posedge clk_in);
    endtask : press
endmodule : msm_panel

// [dv/tb_msm_menu.sv]
// bench for the setup menu block with its own settings model
// assumes short hold parameters stand in for the one and two seconds
`timescale 1ns/10ps
module tb_msm_menu
    import msm_pkg::*;
;
    typedef struct packed {
        msm_settings_type s;
        msm_screen_type   scr;
        logic [15:0]      max;
        logic [4:0]       wid;
        logic [1:0]       sel;
        logic [7:0]       pul;
    } msm_note_type;
    localparam int unsigned EH = 20;
    localparam int unsigned XH = 40;
    logic             clk_in = 1'b0;
    logic             reset_in = 1'b1;
    logic             peak_mode_in = 1'b0;
    logic             transmitting_in = 1'b0;
    logic [7:0]       swr_live_in = 8'h00;
    msm_buttons_type  buttons;
    msm_screen_type   screen_out;
    logic             cpu_reset_out;
    msm_settings_type settings_out;
    msm_bargraph_type bargraph_out;
    logic             attack_fast_out;
    logic [7:0]       swr_rest_out;
    logic             swr_rest_valid_out;
    msm_note_type     notes[$];
    msm_note_type     ex;
    logic [3:0]       idx[3];
    logic [3:0]       lst[3] = '{LOW_LAST, MID_LAST, HIGH_LAST};
    int unsigned      opt[3][10] = '{'{5, 10, 15, 20, 25, 0, 0, 0, 0, 0},
        '{50, 75, 100, 125, 150, 175, 200, 225, 250, 0},
        '{500, 750, 1000, 1250, 1500, 1750, 2000, 2250, 2500, 3000}};
    logic [1:0]       sel = 2'h0;
    logic [4:0]       w = WIDTH_RESET;
    logic [7:0]       np = 8'h00, pulses = 8'h00;
    int unsigned      cal_cnt = 0;
    int               miscompares = 0, compares = 0;
    int               seed = 32'h4fa3bde3;
    event             note_ev;

    always #12.5 clk_in = ~clk_in;
    msm_panel u_panel (.clk_in(clk_in), .buttons_out(buttons));
    msm_menu #(.ENTER_HOLD(EH), .EXIT_HOLD(XH)) DUT (.clk_in(clk_in), .reset_in(reset_in),
        .buttons_in(buttons), .peak_mode_in(peak_mode_in), .transmitting_in(transmitting_in),
        .swr_live_in(swr_live_in), .screen_out(screen_out), .cpu_reset_out(cpu_reset_out),
        .settings_out(settings_out), .bargraph_out(bargraph_out), .attack_fast_out(attack_fast_out),
        .swr_rest_out(swr_rest_out), .swr_rest_valid_out(swr_rest_valid_out));
    always @(posedge clk_in) begin
        if (cpu_reset_out === 1'b1) pulses <= pulses + 8'h01;
        if (screen_out === SCR_CAL) cal_cnt <= cal_cnt + 1;
    end
    ////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("counts: %0d compares, %0d miscompares", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    function automatic int sat(int v, int lo, int hi, bit dn);
        return dn ? (v > lo ? v - 1 : v) : (v < hi ? v + 1 : v);
    endfunction : sat
    function automatic int wrp(int v, int last, bit dn);
        return dn ? (v == 0 ? last : v - 1) : (v == last ? 0 : v + 1);
    endfunction : wrp
    // note settles half a cycle past the bargraph update, off the sampling edge
    task automatic note();
        int unsigned m;
        @(negedge clk_in);
        m = opt[sel][idx[sel]];
        if (ex.s.coupler == COUPLER_5KW_A || ex.s.coupler == COUPLER_5KW_B) m = m * 167 / 100;
        if (ex.s.coupler == COUPLER_10KW) m = m * 333 / 100;
        ex.max = 16'(m);
        ex.sel = sel;
        ex.wid = peak_mode_in ? WIDTH_PEAK : w;
        ex.pul = np;
        notes.push_back(ex);
        -> note_ev;
    endtask : note
    // b: 4 mode, 2 down, 1 up
    task automatic act(input logic [2:0] b);
        int r;
        bit dn;
        r = $random(seed);
        dn = b[1];
        @(posedge clk_in);
        peak_mode_in <= r[0];
        u_panel.press(b, 3);
        if (b == 3'h4) ex.scr = (ex.scr == SCR_LOWER) ? SCR_REF : msm_screen_type'(ex.scr << 1);
        else case (ex.scr)
            SCR_REF:     if (dn) np++; else ex.s.temp_celsius ^= 1'b1;
            SCR_ALARM:   ex.s.swr_setpoint = 6'(sat(ex.s.swr_setpoint, SWR_MIN, SWR_MAX, dn));
            SCR_THRESH:  if (dn) ex.s.alarm_power_threshold = 3'(wrp(ex.s.alarm_power_threshold, 4, 0));
                         else ex.s.power_net ^= 1'b1;
            SCR_RANGE:   if (dn) sel = (sel == 2'h2) ? 2'h0 : sel + 2'h1;
                         else idx[sel] = 4'(wrp(idx[sel], lst[sel], 0));
            SCR_WIDTH:   w = 5'(sat(w, WIDTH_MIN, WIDTH_MAX, dn));
            SCR_AVG:     ex.s.avg_samples = 5'(sat(ex.s.avg_samples, AVG_MIN, AVG_MAX, dn));
            SCR_HOLD:    ex.s.hold_quarters = 5'(sat(ex.s.hold_quarters, HOLD_MIN, HOLD_MAX, dn));
            SCR_DECAY:   ex.s.decay = 2'(sat(ex.s.decay, 0, DECAY_MAX, dn));
            SCR_COUPLER: ex.s.coupler = 3'(wrp(ex.s.coupler, COUPLER_LAST, dn));
            SCR_REST:    ex.s.rest_style = 3'(wrp(ex.s.rest_style, REST_LAST, dn));
            default:     ex.s.lower_reflected ^= 1'b1;
        endcase
        note();
    endtask : act
    always @(note_ev) begin
        msm_note_type n;
        n = notes.pop_front();
        check(settings_out, n.s);
        check(screen_out, n.scr);
        check(bargraph_out.max_watts, n.max);
        check(bargraph_out.span_watts, n.max + n.max / 16'h000A);
        check(bargraph_out.width_db, n.wid);
        check(bargraph_out.scale_sel, n.sel);
        check(pulses, n.pul);
        check(attack_fast_out, 1'b1);
    end
    initial begin
        repeat (100000) @(posedge clk_in);
        miscompares++;
        stop_test();
    end
    ////////////////////////////////////////
    initial begin
        int r;
        ex.s = '{SWR_RESET, THRESH_RESET, 1'b1, 1'b0, AVG_RESET, HOLD_RESET, DECAY_RESET, COUPLER_RESET,
            REST_RESET, 1'b0};
        ex.scr = SCR_OPERATE;
        idx = '{LOW_RESET, MID_RESET, HIGH_RESET};
        repeat (8) @(posedge clk_in);
        reset_in <= 1'b0;
        // bargraph only holds derived values from the first edge after release
        @(posedge clk_in);
        note();
        u_panel.press(3'h4, EH + 5);
        ex.scr = SCR_REF;
        note();
        $display("test reset and entry done");
        // every screen: run to both ends, then random presses, then tap on
        for (int k = 0; k < 11; k++) begin
            repeat (45) act(3'h1);
            repeat (45) act(3'h2);
            repeat (8) begin
                r = $random(seed);
                act(r[0] ? 3'h1 : 3'h2);
            end
            if (ex.scr == SCR_REST) begin
                for (int j = 0; j < 5 && ex.s.rest_style != REST_HOLD; j++) act(3'h1);
                @(posedge clk_in);
                swr_live_in <= 8'h2A;
                transmitting_in <= 1'b1;
                repeat (10) @(posedge clk_in);
                transmitting_in <= 1'b0;
                // live value still stands while the synced transmit level lags the pin
                repeat (4) @(posedge clk_in);
                swr_live_in <= 8'hD5;
                repeat (10) @(posedge clk_in);
                check(swr_rest_valid_out, 1'b1);
                check(swr_rest_out, 8'h2A);
                transmitting_in <= 1'b1;
                repeat (10) @(posedge clk_in);
                check(swr_rest_valid_out, 1'b0);
                transmitting_in <= 1'b0;
            end
            act(3'h4);
            $display("test screen %0d done", k);
        end
        u_panel.press(3'h4, XH + 4);
        ex.scr = SCR_OPERATE;
        note();
        check(cal_cnt, CAL_SHOW_CYCLES);
        $display("test exit done");
        stop_test();
    end
endmodule : tb_msm_menu
